// ==== hw/bst_regs.svh ====
// Boundary-scan port constants: codes, widths, identity fields
`ifndef BST_REGS_SVH
`define BST_REGS_SVH

`define BST_IR_W 4
`define BST_IR_CAPTURE 4'h5
`define BST_BND_W 48
`define BST_ID_W 32
`define BST_OFS_W 16
`define BST_TMS_RESET_CNT 3'h5

`define BST_INS_EXTEST 4'h0
`define BST_INS_SAMPLE 4'h1
`define BST_INS_IDCODE 4'h2
`define BST_INS_CLAMP 4'h3
`define BST_INS_HIGHZ 4'h4
`define BST_INS_OFS_RD 4'h7
`define BST_INS_OFS_WR 4'h8
`define BST_INS_BYPASS 4'hF

// Identity fields, values arbitrary
`define BST_ID_VERSION 4'h1
`define BST_ID_PART 16'h0A5A
`define BST_ID_MFR 11'h2AA

`endif

// ==== hw/bst_pkg.sv ====
// Boundary-scan port types
package bst_pkg;
	typedef enum logic [3:0] {
		ST_TLR = 4'h0,
		ST_RTI = 4'h1,
		ST_SEL_DR = 4'h2,
		ST_CAP_DR = 4'h3,
		ST_SH_DR = 4'h4,
		ST_EX1_DR = 4'h5,
		ST_PA_DR = 4'h6,
		ST_EX2_DR = 4'h7,
		ST_UPD_DR = 4'h8,
		ST_SEL_IR = 4'h9,
		ST_CAP_IR = 4'hA,
		ST_SH_IR = 4'hB,
		ST_EX1_IR = 4'hC,
		ST_PA_IR = 4'hD,
		ST_EX2_IR = 4'hE,
		ST_UPD_IR = 4'hF
	} bst_state_t;
endpackage

// ==== hw/bst_sync.sv ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module bst_sync #(
	parameter int W = 4
) (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
		end
		else
		begin
			meta_reg <= i_d;
			sync_reg <= meta_reg;
		end
	end

	assign o_q = sync_reg;
endmodule // bst_sync

// ==== hw/bst_shift.sv ====
// Capture/shift/hold scan chain, shifts towards bit 0
`timescale 1ns/1ps
module bst_shift #(
	parameter int W = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_capture,
	input wire logic i_shift,
	input wire logic [W-1:0] i_din,
	input wire logic i_si,
	output logic [W-1:0] o_q
);
	logic [W-1:0] chain_reg;
	logic [W-1:0] chain_next;
	logic [W:0] feed;

	assign feed = {i_si, chain_reg};

	genvar g;
	generate
		for (g = 0; g < W; g++)
		begin : g_cell
			assign chain_next[g] = i_capture ? i_din[g] : (i_shift ? feed[g+1] : chain_reg[g]);
		end
	endgenerate

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
			chain_reg <= '0;
		else
			chain_reg <= chain_next;
	end

	assign o_q = chain_reg;
endmodule // bst_shift

// ==== hw/bst_tap.sv ====
// Boundary-scan test access port: controller, instruction and data registers
// Summary of operation
// - Five rising TCK edges with TMS high reach Test-Logic-Reset from anywhere.
// - Power-up reset places the controller in Test-Logic-Reset without TCK.
// - Controller reset precedes queue use; active test modes override queue logic.
// - Apart from power-up and TRST reset, state changes only on rising TCK, next state chosen by sampled TMS.
// - Test-Logic-Reset disables all test logic; device runs normally.
// - Capture-IR loads a fixed pattern whose two low bits are 01.
// - Shift-IR shifts one bit per rising TCK; TDO changes on falling TCK.
// - Update-IR latches the shifted instruction on falling TCK as current.
// - Pause states stop shifting and hold register contents.
// - Capture-DR parallel-loads the selected data register on rising TCK.
// - All data registers share TDI and TDO; instruction picks the path.
// - Bypass is one stage capturing zero in Capture-DR, harmless to operation.
// - Boundary chain holds 48 cells capturing pins and driving outputs.
// - Identity word: 32 bits, version, part, maker code, constant one.
// - Identity instruction code 2 selects the identity word.
// - Instruction is a 4-bit field giving 16 codes.
// - Clamp code 3 drives outputs from boundary chain contents.
// - High-impedance code 4 floats all device outputs.
// - Offset read code 7 shifts out almost-empty and almost-full offsets.
// - External test code 0 drives boundary values out and samples inputs.
// - Bypass, clamp and high-impedance place the bypass stage in the path.
`timescale 1ns/1ps
`include "bst_regs.svh"
module bst_tap (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_tck,
	input wire logic i_tms,
	input wire logic i_tdi,
	input wire logic i_trst_n,
	input wire logic [`BST_BND_W-1:0] i_bnd_capture,
	input wire logic [`BST_OFS_W-1:0] i_ae_offset,
	input wire logic [`BST_OFS_W-1:0] i_af_offset,
	output logic o_tdo,
	output logic o_tdo_oe,
	output logic [`BST_BND_W-1:0] o_bnd_drive,
	output logic o_bnd_mode,
	output logic o_hiz,
	output logic o_test_active,
	output logic [`BST_OFS_W-1:0] o_ae_offset,
	output logic [`BST_OFS_W-1:0] o_af_offset,
	output logic o_offset_wr
);
	logic [3:0] pin_s;
	logic tck_s;
	logic tms_s;
	logic tdi_s;
	logic trst_n_s;
	logic tck_d_reg;
	logic tck_rise;
	logic tck_fall;
	bst_pkg::bst_state_t state_reg;
	bst_pkg::bst_state_t state_next;
	logic [`BST_IR_W-1:0] instr_reg;
	logic [`BST_IR_W-1:0] ir_q;
	logic [`BST_BND_W-1:0] bnd_q;
	logic [`BST_ID_W-1:0] id_q;
	logic [2*`BST_OFS_W-1:0] ofs_q;
	logic byp_reg;
	logic tdo_reg;
	logic tdo_oe_reg;
	logic [`BST_BND_W-1:0] bnd_upd_reg;
	logic bnd_mode_reg;
	logic hiz_reg;
	logic test_active_reg;
	logic [`BST_OFS_W-1:0] ae_reg;
	logic [`BST_OFS_W-1:0] af_reg;
	logic ofs_wr_reg;
	logic in_sh_ir;
	logic in_sh_dr;
	logic ir_cap;
	logic ir_sh;
	logic dr_cap;
	logic dr_sh;
	logic sel_bnd;
	logic sel_id;
	logic sel_ofs;
	logic sel_byp;
	logic dr_so;
	logic tdo_next;
	logic [`BST_ID_W-1:0] id_word;
	logic ins_bnd_mode;
	logic ins_hiz;
	logic ins_test;
	logic [2:0] tms_cnt_reg;

	// Pin inputs cross into the system clock
	bst_sync #(.W(4)) u_sync (
		.i_sys_clk(i_sys_clk),
		.i_reset_n(i_reset_n),
		.i_d({i_trst_n, i_tdi, i_tms, i_tck}),
		.o_q(pin_s)
	);

	assign tck_s = pin_s[0];
	assign tms_s = pin_s[1];
	assign tdi_s = pin_s[2];
	assign trst_n_s = pin_s[3];
	assign tck_rise = tck_s & ~tck_d_reg;
	assign tck_fall = ~tck_s & tck_d_reg;

	// Controller next state from sampled TMS
	always_comb
	begin
		case (state_reg)
			bst_pkg::ST_TLR: state_next = tms_s ? bst_pkg::ST_TLR : bst_pkg::ST_RTI;
			bst_pkg::ST_RTI: state_next = tms_s ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
			bst_pkg::ST_SEL_DR: state_next = tms_s ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
			bst_pkg::ST_CAP_DR: state_next = tms_s ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
			bst_pkg::ST_SH_DR: state_next = tms_s ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
			bst_pkg::ST_EX1_DR: state_next = tms_s ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PA_DR;
			bst_pkg::ST_PA_DR: state_next = tms_s ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PA_DR;
			bst_pkg::ST_EX2_DR: state_next = tms_s ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
			bst_pkg::ST_UPD_DR: state_next = tms_s ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
			bst_pkg::ST_SEL_IR: state_next = tms_s ? bst_pkg::ST_TLR : bst_pkg::ST_CAP_IR;
			bst_pkg::ST_CAP_IR: state_next = tms_s ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
			bst_pkg::ST_SH_IR: state_next = tms_s ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
			bst_pkg::ST_EX1_IR: state_next = tms_s ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PA_IR;
			bst_pkg::ST_PA_IR: state_next = tms_s ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PA_IR;
			bst_pkg::ST_EX2_IR: state_next = tms_s ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
			bst_pkg::ST_UPD_IR: state_next = tms_s ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
			default: state_next = bst_pkg::ST_TLR;
		endcase
	end

	// Power-up and TRST force reset; otherwise step on rising TCK
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n || !trst_n_s)
			state_reg <= bst_pkg::ST_TLR;
		else if (tck_rise)
			state_reg <= state_next;
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
			tck_d_reg <= 1'b0;
		else
			tck_d_reg <= tck_s;
	end

	// State qualified strobes; pause states give neither, so chains hold
	assign in_sh_ir = (state_reg == bst_pkg::ST_SH_IR);
	assign in_sh_dr = (state_reg == bst_pkg::ST_SH_DR);
	assign ir_cap = tck_rise && (state_reg == bst_pkg::ST_CAP_IR);
	assign ir_sh = tck_rise && in_sh_ir;
	assign dr_cap = tck_rise && (state_reg == bst_pkg::ST_CAP_DR);
	assign dr_sh = tck_rise && in_sh_dr;

	// Instruction decode
	assign sel_bnd = (instr_reg == `BST_INS_EXTEST) || (instr_reg == `BST_INS_SAMPLE);
	assign sel_id = (instr_reg == `BST_INS_IDCODE);
	assign sel_ofs = (instr_reg == `BST_INS_OFS_RD) || (instr_reg == `BST_INS_OFS_WR);
	assign sel_byp = !(sel_bnd || sel_id || sel_ofs);
	assign ins_bnd_mode = (instr_reg == `BST_INS_EXTEST) || (instr_reg == `BST_INS_CLAMP);
	assign ins_hiz = (instr_reg == `BST_INS_HIGHZ);
	assign ins_test = ins_bnd_mode || ins_hiz || sel_ofs;
	assign id_word = {`BST_ID_VERSION, `BST_ID_PART, `BST_ID_MFR, 1'b1};

	// Instruction chain, 4 bits
	bst_shift #(.W(`BST_IR_W)) u_ir (
		.i_sys_clk(i_sys_clk),
		.i_reset_n(i_reset_n),
		.i_capture(ir_cap),
		.i_shift(ir_sh),
		.i_din(`BST_IR_CAPTURE),
		.i_si(tdi_s),
		.o_q(ir_q)
	);

	// Boundary chain of 48 cells
	bst_shift #(.W(`BST_BND_W)) u_bnd (
		.i_sys_clk(i_sys_clk),
		.i_reset_n(i_reset_n),
		.i_capture(dr_cap && sel_bnd),
		.i_shift(dr_sh && sel_bnd),
		.i_din(i_bnd_capture),
		.i_si(tdi_s),
		.o_q(bnd_q)
	);

	// Identity word, read only
	bst_shift #(.W(`BST_ID_W)) u_id (
		.i_sys_clk(i_sys_clk),
		.i_reset_n(i_reset_n),
		.i_capture(dr_cap && sel_id),
		.i_shift(dr_sh && sel_id),
		.i_din(id_word),
		.i_si(tdi_s),
		.o_q(id_q)
	);

	// Threshold offsets, almost-empty in the low half
	bst_shift #(.W(2*`BST_OFS_W)) u_ofs (
		.i_sys_clk(i_sys_clk),
		.i_reset_n(i_reset_n),
		.i_capture(dr_cap && sel_ofs),
		.i_shift(dr_sh && sel_ofs),
		.i_din({i_af_offset, i_ae_offset}),
		.i_si(tdi_s),
		.o_q(ofs_q)
	);

	// Bypass stage
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
			byp_reg <= 1'b0;
		else if (dr_cap && sel_byp)
			byp_reg <= 1'b0;
		else if (dr_sh && sel_byp)
			byp_reg <= tdi_s;
	end

	// Shared serial output selection
	assign dr_so = sel_bnd ? bnd_q[0] : (sel_id ? id_q[0] : (sel_ofs ? ofs_q[0] : byp_reg));
	assign tdo_next = in_sh_ir ? ir_q[0] : dr_so;

	// TDO and its enable change on falling TCK only
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
		begin
			tdo_reg <= 1'b0;
			tdo_oe_reg <= 1'b0;
		end
		else if (tck_fall)
		begin
			tdo_reg <= tdo_next;
			tdo_oe_reg <= in_sh_ir || in_sh_dr;
		end
	end

	// Current instruction
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n || state_reg == bst_pkg::ST_TLR)
			instr_reg <= `BST_INS_IDCODE;
		else if (tck_fall && state_reg == bst_pkg::ST_UPD_IR)
			instr_reg <= ir_q;
	end

	// Boundary update stage and test mode outputs
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
			bnd_upd_reg <= '0;
		else if (tck_fall && state_reg == bst_pkg::ST_UPD_DR && sel_bnd)
			bnd_upd_reg <= bnd_q;
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
		begin
			bnd_mode_reg <= 1'b0;
			hiz_reg <= 1'b0;
			test_active_reg <= 1'b0;
		end
		else
		begin
			bnd_mode_reg <= ins_bnd_mode;
			hiz_reg <= ins_hiz;
			test_active_reg <= ins_test;
		end
	end

	// Offset write-back on Update-DR
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
		begin
			ae_reg <= '0;
			af_reg <= '0;
			ofs_wr_reg <= 1'b0;
		end
		else
		begin
			ofs_wr_reg <= tck_fall && state_reg == bst_pkg::ST_UPD_DR
				&& instr_reg == `BST_INS_OFS_WR;
			if (tck_fall && state_reg == bst_pkg::ST_UPD_DR && instr_reg == `BST_INS_OFS_WR)
			begin
				ae_reg <= ofs_q[`BST_OFS_W-1:0];
				af_reg <= ofs_q[2*`BST_OFS_W-1:`BST_OFS_W];
			end
		end
	end

	assign o_tdo = tdo_reg;
	assign o_tdo_oe = tdo_oe_reg;
	assign o_bnd_drive = bnd_upd_reg;
	assign o_bnd_mode = bnd_mode_reg;
	assign o_hiz = hiz_reg;
	assign o_test_active = test_active_reg;
	assign o_ae_offset = ae_reg;
	assign o_af_offset = af_reg;
	assign o_offset_wr = ofs_wr_reg;

	// Checking helper: consecutive TMS-high rising edges
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
			tms_cnt_reg <= 3'h0;
		else if (tck_rise)
			tms_cnt_reg <= tms_s ? ((tms_cnt_reg == `BST_TMS_RESET_CNT) ? tms_cnt_reg
				: tms_cnt_reg + 3'h1) : 3'h0;
	end

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_reset_n);

	AST_TMS_RESET: assert property (
		tms_cnt_reg == `BST_TMS_RESET_CNT |-> state_reg == bst_pkg::ST_TLR)
		else $error("five TMS-high edges did not reach reset");
	AST_POWERUP: assert property (disable iff (1'b0)
		!i_reset_n |=> state_reg == bst_pkg::ST_TLR)
		else $error("controller not in reset after power-up");
	AST_STEP_ON_RISE: assert property (
		!tck_rise && trst_n_s |=> $stable(state_reg))
		else $error("state moved without rising TCK");
	AST_TLR_NORMAL: assert property (
		(state_reg == bst_pkg::ST_TLR) [*3] |-> !o_test_active && !o_hiz && !o_bnd_mode)
		else $error("test logic active in reset state");
	AST_CAPTURE_IR: assert property (
		ir_cap |=> ir_q[1:0] == 2'b01)
		else $error("capture pattern low bits not 01");
	AST_TDO_FALL: assert property (
		!tck_fall |=> $stable(o_tdo) && $stable(o_tdo_oe))
		else $error("TDO changed outside falling TCK");
	AST_UPDATE_IR: assert property (
		tck_fall && state_reg == bst_pkg::ST_UPD_IR |=> instr_reg == $past(ir_q))
		else $error("instruction not latched in Update-IR");
	AST_PAUSE_HOLD: assert property (
		state_reg == bst_pkg::ST_PA_DR || state_reg == bst_pkg::ST_PA_IR
		|=> $stable(ir_q) && $stable(bnd_q) && $stable(ofs_q))
		else $error("chain moved during pause");
	AST_BYPASS_ZERO: assert property (
		dr_cap && sel_byp |=> !byp_reg)
		else $error("bypass did not capture zero");
	AST_ID_CAPTURE: assert property (
		dr_cap && sel_id |=> id_q == id_word && id_q[0])
		else $error("identity word wrong after capture");
	AST_HIZ: assert property (
		instr_reg == `BST_INS_HIGHZ |=> o_hiz)
		else $error("outputs not floated under high-impedance");
	AST_TDO_OE: assert property (
		tck_fall && !in_sh_ir && !in_sh_dr |=> !o_tdo_oe)
		else $error("TDO driven outside shift states");
	AST_TLR_IDCODE: assert property (
		state_reg == bst_pkg::ST_TLR |=> instr_reg == `BST_INS_IDCODE)
		else $error("identity instruction not current in reset");

	COV_UPDATE_IR: cover property (tck_fall && state_reg == bst_pkg::ST_UPD_IR);
	COV_BND_SHIFT: cover property (dr_sh && sel_bnd);
	COV_OFS_WRITE: cover property (o_offset_wr);
	COV_PAUSE_DR: cover property (state_reg == bst_pkg::ST_PA_DR ##1 state_reg == bst_pkg::ST_EX2_DR);
endmodule // bst_tap

// ==== bench/bst_master.sv ====
// Scan master model: drives the test clock, mode and data pins
`timescale 1ns/1ps
module bst_master (
	input wire logic i_tdo,
	input wire logic i_tdo_oe,
	output logic o_tck,
	output logic o_tms,
	output logic o_tdi
);
	initial
	begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b0;
	end
	// One clock period; pins change at the fall, TDO taken mid high phase
	task automatic step(input logic tms, input logic tdi, output logic tdo);
		o_tms = tms;
		o_tdi = tdi;
		#100;
		o_tck = 1'b1;
		#50;
		tdo = i_tdo_oe ? i_tdo : 1'bx;
		#50;
		o_tck = 1'b0;
	endtask
	// Moves the controller; data line toggles while unused
	task automatic nav(input logic tms);
		logic t;
		step(tms, ~o_tdi, t);
	endtask
	// Five rising edges with mode high, then to idle
	task automatic reset5();
		repeat (5) nav(1'b1);
		nav(1'b0);
	endtask
	// Scan n bits from idle and back; no serial threshold pins exist here
	task automatic scan(input logic is_ir, input int n, input int pause_at,
		input logic [63:0] din, output logic [63:0] dout);
		logic t;
		dout = '0;
		nav(1'b1);
		if (is_ir)
			nav(1'b1);
		nav(1'b0);
		nav(1'b0);
		for (int i = 0; i < n; i++)
		begin
			step((i == n - 1) || (i == pause_at), din[i], t);
			dout[i] = t;
			if (i == pause_at)
			begin
				nav(1'b0);
				nav(1'b0);
				nav(1'b1);
				nav(1'b0);
			end
		end
		nav(1'b1);
		nav(1'b0);
	endtask
endmodule // bst_master

// ==== bench/bst_tap_test.sv ====
// Self-checking bench for the boundary-scan port
`timescale 1ns/1ps
`include "bst_regs.svh"
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin miscompares++; \
	$display("mismatch %s exp %0h got %0h", nm, ex, gt); end end
module bst_tap_test;
	logic sys_clk;
	logic reset_n;
	logic trst_n;
	logic tck;
	logic tms;
	logic tdi;
	logic tdo;
	logic tdo_oe;
	logic [47:0] cap;
	logic [15:0] ae;
	logic [15:0] af;
	logic [47:0] bnd_drive;
	logic bnd_mode;
	logic hiz;
	logic test_active;
	logic [15:0] ae_out;
	logic [15:0] af_out;
	logic offset_wr;
	int checks = 0;
	int miscompares = 0;
	int wr_pulses = 0;
	localparam logic [31:0] ID = {`BST_ID_VERSION, `BST_ID_PART, `BST_ID_MFR, 1'b1};

	bst_tap dut_u (
		.i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_tck(tck), .i_tms(tms),
		.i_tdi(tdi), .i_trst_n(trst_n), .i_bnd_capture(cap), .i_ae_offset(ae),
		.i_af_offset(af), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_bnd_drive(bnd_drive),
		.o_bnd_mode(bnd_mode), .o_hiz(hiz), .o_test_active(test_active),
		.o_ae_offset(ae_out), .o_af_offset(af_out), .o_offset_wr(offset_wr)
	);
	bst_master m_u (.i_tdo(tdo), .i_tdo_oe(tdo_oe), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));

	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
		if (offset_wr === 1'b1)
			wr_pulses <= wr_pulses + 1;

	task automatic wrap_up();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic ir(input logic [3:0] code);
		logic [63:0] o;
		m_u.scan(1'b1, 4, -1, {60'h0, code}, o); // Defined codes only
		`CHK("ir capture", `BST_IR_CAPTURE, o[3:0])
	endtask
	task automatic t_id(input string nm);
		logic [63:0] o;
		m_u.scan(1'b0, 32, -1, 64'h0, o);
		`CHK("identity", ID, o[31:0])
		`CHK("tdo enable idle", 1'b0, tdo_oe)
		$display("test %s done", nm);
	endtask
	task automatic t_power_up();
		`CHK("modes at reset", 3'b000, {bnd_mode, hiz, test_active})
		`CHK("tdo enable at reset", 1'b0, tdo_oe)
		m_u.nav(1'b0);
		t_id("power_up");
	endtask
	task automatic t_bypass();
		logic [63:0] o;
		ir(`BST_INS_BYPASS);
		m_u.scan(1'b0, 3, 0, 64'h3, o);
		`CHK("bypass path", 3'b110, o[2:0])
		$display("test bypass done");
	endtask
	task automatic t_modes();
		logic [63:0] o;
		logic [3:0] cd [7] = '{`BST_INS_EXTEST, `BST_INS_SAMPLE, `BST_INS_IDCODE,
			`BST_INS_CLAMP, `BST_INS_HIGHZ, `BST_INS_OFS_RD, `BST_INS_BYPASS};
		logic [2:0] md [7] = '{3'b101, 3'b000, 3'b000, 3'b101, 3'b011, 3'b001, 3'b000};
		logic [1:0] fb [7] = '{2'b00, 2'b00, 2'b01, 2'b10, 2'b10, 2'b01, 2'b10};
		for (int k = 0; k < 7; k++)
		begin
			ir(cd[k]);
			`CHK("mode", md[k], {bnd_mode, hiz, test_active})
			m_u.scan(1'b0, 2, -1, 64'h1, o);
			`CHK("dr path", fb[k], o[1:0])
		end
		$display("test modes done");
	endtask
	task automatic t_boundary();
		logic [63:0] o;
		ir(`BST_INS_SAMPLE);
		m_u.scan(1'b0, 48, 20, {16'h0, 48'h3C96_5AF0_1287}, o);
		`CHK("boundary capture", cap, o[47:0])
		`CHK("boundary preload", 48'h3C96_5AF0_1287, bnd_drive)
		cap = 48'h1E2D_3C4B_5A69;
		ir(`BST_INS_EXTEST);
		`CHK("extest drive", 3'b101, {bnd_mode, hiz, test_active})
		m_u.scan(1'b0, 48, -1, 64'h0, o);
		`CHK("extest sample", 48'h1E2D_3C4B_5A69, o[47:0])
		$display("test boundary done");
	endtask
	task automatic t_offsets();
		logic [63:0] o;
		ir(`BST_INS_OFS_RD);
		m_u.scan(1'b0, 32, -1, 64'h0, o);
		`CHK("offset read", {af, ae}, o[31:0])
		ir(`BST_INS_OFS_WR);
		m_u.scan(1'b0, 32, -1, 64'h0F0F_7531, o);
		`CHK("ae written", 16'h7531, ae_out)
		`CHK("af written", 16'h0F0F, af_out)
		`CHK("write pulses", 1, wr_pulses)
		$display("test offsets done");
	endtask
	task automatic t_tms_reset();
		m_u.nav(1'b1);
		m_u.nav(1'b0);
		m_u.nav(1'b0);
		m_u.reset5();
		`CHK("modes after tms reset", 3'b000, {bnd_mode, hiz, test_active})
		t_id("tms_reset");
	endtask
	task automatic t_trst();
		ir(`BST_INS_EXTEST);
		@(posedge sys_clk);
		#1 trst_n = 1'b0;
		repeat (4) @(posedge sys_clk);
		#1 trst_n = 1'b1;
		repeat (4) @(posedge sys_clk);
		#1;
		`CHK("modes after test reset", 3'b000, {bnd_mode, hiz, test_active})
		m_u.nav(1'b0);
		t_id("trst");
	endtask

	initial
	begin
		reset_n = 1'b0;
		trst_n = 1'b1;
		cap = 48'hA5C3_0F1E_9B24;
		ae = 16'h1235;
		af = 16'hBEEF;
		repeat (2) @(posedge sys_clk);
		#1 reset_n = 1'b1;
		repeat (4) @(posedge sys_clk);
		#1;
		t_power_up();
		t_bypass();
		t_modes();
		t_boundary();
		t_offsets();
		t_tms_reset();
		t_trst();
		wrap_up();
	end
	initial
	begin
		#500_000;
		miscompares++;
		wrap_up();
	end
endmodule // bst_tap_test
